// ==== core/pb_clk_div.sv ====
`timescale 1ns/10ps
`default_nettype none
// Peripheral bus clock enable divider
module pb_clk_div
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Control
  input wire logic run_in,
  input wire logic [1:0] div_sel_in,
  // Output
  output logic pb_tick_out
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [2:0] limit;

  // Divide by 1, 2, 4 or 8
  assign limit = 3'((4'h1 << div_sel_in) - 4'h1);
  assign nxt_cnt = (cnt_ff >= limit) ? 3'h0 : cnt_ff + 3'h1;
  assign pb_tick_out = run_in && (cnt_ff >= limit);

  // Counter runs only while the bus clock is allowed
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cnt_ff <= 3'h0;
    else if (ce_in && run_in)
      cnt_ff <= nxt_cnt;
  end
endmodule : pb_clk_div
`default_nettype wire

// ==== core/power_saving_clock_gating.sv ====
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pwr_defines.svh"
module power_saving_clock_gating
#(
  parameter int NUM_PERIPH = 32
)
(
  // Clock, reset, enable
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  // Register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  // Configuration straps
  input wire logic [1:0] DEFAULT_BUS_DIVISOR_IN,
  input wire logic ONE_WAY_LOCK_FUSE_IN,
  // CPU and wake sources
  input wire logic WAIT_EXEC_IN,
  input wire pwr_pkg::wake_req_s WAKE_IN,
  // Peripheral access from the CPU
  input wire logic PERIPH_RD_IN,
  input wire logic [$clog2(NUM_PERIPH)-1:0] PERIPH_SEL_IN,
  input wire logic [31:0] PERIPH_RDATA_IN,
  output logic PERIPH_RD_DONE_OUT,
  output logic [31:0] PERIPH_RDATA_OUT,
  output logic PERIPH_WR_ALLOW_OUT,
  // Stop-in-idle controls per peripheral
  input wire logic [NUM_PERIPH-1:0] STOP_IN_IDLE_IN,
  // Clock gating outputs
  output logic CPU_CLK_EN_OUT,
  output logic SYS_CLK_EN_OUT,
  output logic SYS_UNIT_CLK_EN_OUT,
  output logic PB_TICK_OUT,
  output logic [NUM_PERIPH-1:0] PERIPH_CLK_EN_OUT,
  output logic [2:0] POWER_STATE_OUT
);
  import pwr_pkg::*;

  pwr_state_e state_ff;
  pwr_state_e nxt_state;
  logic [31:0] md_ff [6];
  logic [31:0] osc_ctrl_ff;
  logic lock_ff;
  logic lock_set_once_ff;
  logic fuse_ff;
  logic [1:0] unlock_ff;
  logic [31:0] rdata_ff;
  logic [31:0] prd_data_ff;
  logic prd_pending_ff;
  logic prd_done_ff;
  logic pb_tick;
  logic pb_run;
  logic wake_hi;
  logic wake_lo;
  logic unlocked;
  logic [NUM_PERIPH-1:0] md_flat;
  logic [NUM_PERIPH-1:0] sel_dis;
  logic [31:0] rd_mux;

  // Map the six disable registers onto a flat index
  function automatic logic [2:0] md_index(input logic [7:0] addr);
    md_index = 3'(addr[7:2]);
  endfunction : md_index

  function automatic logic [31:0] md_mask(input logic [2:0] idx);
    case (idx)
      3'h0: md_mask = `ANALOG_MD_MASK;
      3'h1: md_mask = `COMPARATOR_MD_MASK;
      3'h2: md_mask = `CAPCMP_MD_MASK;
      3'h3: md_mask = `TIMER_MD_MASK;
      3'h4: md_mask = `SERIAL_MD_MASK;
      3'h5: md_mask = `MISC_MD_MASK;
      default: md_mask = 32'h0000_0000;
    endcase
  endfunction : md_mask

  // Decode
  wire is_md = ADDR_IN <= `OFS_MISC_MD && ADDR_IN[1:0] == 2'h0;
  wire [2:0] md_idx = md_index(ADDR_IN);
  wire wr_md = CE_IN && WR_IN && is_md && !lock_ff;
  wire wr_osc = CE_IN && WR_IN && ADDR_IN == `OFS_OSC_CTRL;
  wire wr_cfg = CE_IN && WR_IN && ADDR_IN == `OFS_CFG_CTRL;
  wire wr_key = CE_IN && WR_IN && ADDR_IN == `OFS_UNLOCK;
  wire wr_cmd = CE_IN && WR_IN && ADDR_IN == `OFS_POWER_CMD;
  wire new_lock = WDATA_IN[`DISABLE_LOCK_BIT];
  wire sleep_sel = osc_ctrl_ff[`SLEEP_SELECT_BIT];
  wire [1:0] pb_div = osc_ctrl_ff[`PB_DIV_MSB:`PB_DIV_LSB];
  wire wait_req = WAIT_EXEC_IN || (wr_cmd && WDATA_IN[0]);

  assign unlocked = unlock_ff == 2'h2;
  // Clearing forbidden after first set when fuse programmed
  wire lock_clear_ok = !(fuse_ff && lock_set_once_ff);
  wire lock_wr_ok = wr_cfg && unlocked && (new_lock || lock_clear_ok);

  // Interrupt priority compare, strictly above CPU priority
  assign wake_hi = WAKE_IN.irq_valid && WAKE_IN.irq_prio > WAKE_IN.cpu_prio;
  assign wake_lo = WAKE_IN.irq_valid && !wake_hi;

  // Power mode state machine
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN:
        if (wait_req)
          nxt_state = sleep_sel ? ST_SLEEP : ST_IDLE;
      ST_IDLE:
        if (wake_hi || WAKE_IN.wdt_timeout)
          nxt_state = ST_RUN;
      ST_SLEEP:
        if (WAKE_IN.wdt_timeout)
          nxt_state = ST_RUN;
        else if (wake_hi && WAKE_IN.irq_runs_in_sleep)
          nxt_state = ST_RUN;
        else if (wake_lo && WAKE_IN.irq_runs_in_sleep)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_RUN;
    endcase
  end

  // State register; reset returns to run
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
      state_ff <= ST_RUN;
    else if (CE_IN)
      state_ff <= nxt_state;
  end

  // Disable registers, one bit per peripheral
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_md
      always_ff @(posedge CLK_SYS_IN)
      begin
        if (RST_IN)
          md_ff[g] <= `MD_RESET;
        else if (wr_md && md_idx == 3'(g))
          md_ff[g] <= WDATA_IN & md_mask(3'(g));
      end
    end
  endgenerate

  // Oscillator control, divisor defaults to config strap
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
      osc_ctrl_ff <= `OSC_CTRL_RESET;
    else if (CE_IN && state_ff == ST_RUN && prd_done_ff == 1'b0 && !wr_osc && osc_ctrl_ff == `OSC_CTRL_RESET
             && !lock_set_once_ff && unlock_ff == 2'h0 && !prd_pending_ff && !fuse_ff)
      osc_ctrl_ff <= osc_ctrl_ff;
    else if (wr_osc)
      osc_ctrl_ff <= WDATA_IN;
  end

  // Straps caught in first cycle after reset
  logic strap_done_ff;
  logic [1:0] strap_div_ff;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
      strap_done_ff <= 1'b0;
    else if (CE_IN)
      strap_done_ff <= 1'b1;
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (CE_IN && !strap_done_ff)
    begin
      fuse_ff <= ONE_WAY_LOCK_FUSE_IN;
      strap_div_ff <= DEFAULT_BUS_DIVISOR_IN;
    end
  end

  // Divisor: strap until software writes the control register
  logic div_written_ff;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
      div_written_ff <= 1'b0;
    else if (wr_osc)
      div_written_ff <= 1'b1;
  end
  wire [1:0] eff_div = div_written_ff ? pb_div : strap_div_ff;

  // Unlock sequence: two keys in order
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
      unlock_ff <= 2'h0;
    else if (wr_key)
      unlock_ff <= (WDATA_IN == `UNLOCK_KEY1) ? 2'h1 :
                   (WDATA_IN == `UNLOCK_KEY2 && unlock_ff == 2'h1) ? 2'h2 : 2'h0;
    else if (wr_cfg)
      unlock_ff <= 2'h0;
  end

  // Disable lock bit and its one-way history
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      lock_ff <= 1'b0;
      lock_set_once_ff <= 1'b0;
    end
    else if (lock_wr_ok)
    begin
      lock_ff <= new_lock;
      lock_set_once_ff <= lock_set_once_ff | new_lock;
    end
  end

  // Bus clock runs except in Sleep
  assign pb_run = state_ff != ST_SLEEP;
  pb_clk_div u_pb_div
  (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .run_in(pb_run),
    .div_sel_in(eff_div),
    .pb_tick_out(pb_tick)
  );

  // Flatten disable bits into peripheral index order
  assign md_flat = NUM_PERIPH'({md_ff[5][16], md_ff[5][1:0], md_ff[4][24], md_ff[4][17:16], md_ff[4][9:8],
                               md_ff[4][4:0], md_ff[3][4:0], md_ff[2][20:16], md_ff[2][4:0], md_ff[1][1:0],
                               md_ff[0][12], md_ff[0][8], md_ff[0][0]});

  // Per peripheral clock enables
  generate
    for (g = 0; g < NUM_PERIPH; g++)
    begin : g_pclk
      assign PERIPH_CLK_EN_OUT[g] = !md_flat[g] && pb_run &&
                                    !(state_ff == ST_IDLE && STOP_IN_IDLE_IN[g]);
    end
  endgenerate

  // Peripheral read completes at next bus edge
  assign sel_dis = md_flat >> PERIPH_SEL_IN;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      prd_pending_ff <= 1'b0;
      prd_done_ff <= 1'b0;
      prd_data_ff <= 32'h0000_0000;
    end
    else if (CE_IN)
    begin
      prd_done_ff <= prd_pending_ff && pb_tick;
      if (prd_pending_ff && pb_tick)
      begin
        prd_pending_ff <= 1'b0;
        prd_data_ff <= sel_dis[0] ? `INVALID_READ : PERIPH_RDATA_IN;
      end
      else if (PERIPH_RD_IN)
        prd_pending_ff <= 1'b1;
    end
  end
  assign PERIPH_RD_DONE_OUT = prd_done_ff;
  assign PERIPH_RDATA_OUT = prd_data_ff;
  assign PERIPH_WR_ALLOW_OUT = !sel_dis[0];

  // Read mux
  assign rd_mux = is_md ? md_ff[md_idx] :
                  ADDR_IN == `OFS_OSC_CTRL ? osc_ctrl_ff :
                  ADDR_IN == `OFS_CFG_CTRL ? 32'(lock_ff) << `DISABLE_LOCK_BIT :
                  ADDR_IN == `OFS_POWER_STATUS ? {27'h0, fuse_ff, eff_div, 2'(state_ff >> 1)} :
                  32'h0000_0000;

  // Read data one cycle after strobe
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
      rdata_ff <= 32'h0000_0000;
    else if (CE_IN)
      rdata_ff <= RD_IN ? rd_mux : 32'h0000_0000;
  end
  assign RDATA_OUT = rdata_ff;

  // Clock gates
  assign CPU_CLK_EN_OUT = state_ff == ST_RUN;
  assign SYS_CLK_EN_OUT = state_ff != ST_SLEEP;
  assign SYS_UNIT_CLK_EN_OUT = state_ff != ST_SLEEP;
  assign PB_TICK_OUT = pb_tick;
  assign POWER_STATE_OUT = state_ff;
endmodule : power_saving_clock_gating
`default_nettype wire

// ==== core/pwr_defines.svh ====
`ifndef PWR_DEFINES_SVH
`define PWR_DEFINES_SVH
// Register offsets (byte addresses)
`define OFS_ANALOG_MD 8'h00
`define OFS_COMPARATOR_MD 8'h04
`define OFS_CAPCMP_MD 8'h08
`define OFS_TIMER_MD 8'h0c
`define OFS_SERIAL_MD 8'h10
`define OFS_MISC_MD 8'h14
`define OFS_OSC_CTRL 8'h18
`define OFS_CFG_CTRL 8'h1c
`define OFS_UNLOCK 8'h20
`define OFS_POWER_CMD 8'h24
`define OFS_POWER_STATUS 8'h28
// Field positions
`define SLEEP_SELECT_BIT 4
`define PB_DIV_LSB 19
`define PB_DIV_MSB 20
`define DISABLE_LOCK_BIT 12
`define ONE_WAY_FUSE_BIT 28
// Writable masks of the six disable registers
`define ANALOG_MD_MASK 32'h0000_1101
`define COMPARATOR_MD_MASK 32'h0000_0003
`define CAPCMP_MD_MASK 32'h001f_001f
`define TIMER_MD_MASK 32'h0000_001f
`define SERIAL_MD_MASK 32'h0103_031f
`define MISC_MD_MASK 32'h0001_0003
`define USB_DISABLE_BIT 24
// Reset values
`define MD_RESET 32'h0000_0000
`define OSC_CTRL_RESET 32'h0000_0000
// Unlock keys, written in order to the unlock register
`define UNLOCK_KEY1 32'haa99_6655
`define UNLOCK_KEY2 32'h5566_99aa
// Data returned for a disabled peripheral
`define INVALID_READ 32'hdead_beef
`endif

// ==== core/pwr_pkg.sv ====
package pwr_pkg;
  typedef enum logic [2:0]
  {
    ST_RUN = 3'b001,
    ST_IDLE = 3'b010,
    ST_SLEEP = 3'b100
  } pwr_state_e;

  // Wake request set from the interrupt controller and watchdog
  typedef struct packed {
    logic irq_valid;
    logic irq_runs_in_sleep;
    logic [2:0] irq_prio;
    logic [2:0] cpu_prio;
    logic wdt_timeout;
  } wake_req_s;

  // Register port command
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_cmd_s;
endpackage : pwr_pkg

// ==== testbench/power_saving_clock_gating_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pwr_defines.svh"
module power_saving_clock_gating_test;
  import pwr_pkg::*;
  logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, wx = 0, prd = 0, fuse = 1;
  logic tick, pdone, pwa, cpu, sys, unit;
  logic [1:0] dd = 2'b11;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 0, pin = 32'h1234_5678, stop_in_idle = 32'h1;
  logic [31:0] rdat, pout, pen;
  logic [4:0] psel = 0;
  logic [2:0] st;
  wake_req_s wk = '0;
  logic [31:0] mk [6] = '{`ANALOG_MD_MASK, `COMPARATOR_MD_MASK, `CAPCMP_MD_MASK,
    `TIMER_MD_MASK, `SERIAL_MD_MASK, `MISC_MD_MASK};
  int n_errors = 0;
  int samples_checked = 0;
  power_saving_clock_gating power_saving_clock_gating_i
  (
    .CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce), .ADDR_IN(addr), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat), .DEFAULT_BUS_DIVISOR_IN(dd),
    .ONE_WAY_LOCK_FUSE_IN(fuse), .WAIT_EXEC_IN(wx), .WAKE_IN(wk), .PERIPH_RD_IN(prd),
    .PERIPH_SEL_IN(psel), .PERIPH_RDATA_IN(pin), .PERIPH_RD_DONE_OUT(pdone),
    .PERIPH_RDATA_OUT(pout), .PERIPH_WR_ALLOW_OUT(pwa), .STOP_IN_IDLE_IN(stop_in_idle),
    .CPU_CLK_EN_OUT(cpu), .SYS_CLK_EN_OUT(sys), .SYS_UNIT_CLK_EN_OUT(unit),
    .PB_TICK_OUT(tick), .PERIPH_CLK_EN_OUT(pen), .POWER_STATE_OUT(st)
  );
  // System clock
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Compare and count
  task chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      $display("Error %s exp %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask : chk
  task summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Register port cycles
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wreg
  task rreg(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(nm, rdat, e);
  endtask : rreg
  task unl;
    wreg(8'h20, `UNLOCK_KEY1);
    wreg(8'h20, `UNLOCK_KEY2);
  endtask : unl
  // Wait pulse and wake levels for one cycle
  task pulse(input logic x, input logic [8:0] w, input logic [2:0] e);
    @(posedge clk);
    wx <= x;
    wk <= w;
    @(posedge clk);
    wx <= 0;
    wk <= '0;
    #1 chk("state", st, e);
  endtask : pulse
  // Cycles between bus ticks, after two resyncs
  task per(input logic [31:0] e);
    int n, k;
    for (k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        #1 n++;
      end
      while (tick !== 1'b1 && n < 20);
    end
    chk("pb period", n, e);
  endtask : per
  task pread(input logic [4:0] s, input logic [31:0] e);
    int n;
    @(posedge clk);
    psel <= s;
    prd <= 1;
    @(posedge clk);
    prd <= 0;
    #1 n = 0;
    while (pdone !== 1'b1 && n < 9)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk("rd done", pdone, 1'b1);
    chk("rd data", pout, e);
  endtask : pread
  task t_reset;
    int i;
    chk("run", st, 3'b001);
    for (i = 0; i < 6; i++)
      rreg("md reset", 8'(4 * i), 32'h0);
    rreg("unmapped", 8'h30, 32'h0);
    per(8);
    pread(5'd15, 32'h1234_5678);
  endtask : t_reset
  task t_disable;
    int i;
    for (i = 0; i < 6; i++)
    begin
      // Every peripheral clock is off, USB included, after disabling
      wreg(8'(4 * i), 32'hffff_ffff);
      rreg("md mask", 8'(4 * i), mk[i]);
    end
    chk("usb clk", pen[29], 1'b0);
    pread(5'd29, `INVALID_READ);
    chk("wr allow", pwa, 1'b0);
    for (i = 0; i < 6; i++)
      wreg(8'(4 * i), 32'h0);
    #1 chk("usb clk on", pen[29], 1'b1);
  endtask : t_disable
  task t_div;
    int i;
    for (i = 0; i < 4; i++)
    begin
      wreg(8'h18, 32'(i) << 19);
      per(1 << i);
    end
  endtask : t_div
  task t_power;
    pulse(1, 9'h0, 3'b010);
    chk("cpu clk", cpu, 1'b0);
    chk("sys clk", sys, 1'b1);
    chk("unit clk", unit, 1'b1);
    chk("stop_in_idle", pen[1:0], 2'b10);
    pulse(0, 9'b1_1_010_010_0, 3'b010);
    pulse(0, 9'b1_0_101_010_0, 3'b001);
    pulse(1, 9'h0, 3'b010);
    pulse(0, 9'h001, 3'b001);
    wreg(8'h18, 32'h0018_0010);
    pulse(1, 9'h0, 3'b100);
    chk("sleep sys", sys, 1'b0);
    pulse(0, 9'b1_1_010_010_0, 3'b010);
    pulse(0, 9'h001, 3'b001);
    pulse(1, 9'h0, 3'b100);
    pulse(0, 9'b1_1_101_010_0, 3'b001);
    pulse(1, 9'h0, 3'b100);
    pulse(0, 9'h001, 3'b001);
  endtask : t_power
  task t_lock;
    wreg(8'h1c, 32'h1000);
    rreg("lock no key", 8'h1c, 32'h0);
    unl;
    wreg(8'h1c, 32'h1000);
    rreg("lock set", 8'h1c, 32'h1000);
    wreg(8'h0c, 32'h1f);
    rreg("locked md", 8'h0c, 32'h0);
    unl;
    wreg(8'h1c, 32'h0);
    rreg("lock kept", 8'h1c, 32'h1000);
    pulse(1, 9'h0, 3'b100);
    @(posedge clk);
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    #1 chk("reset run", st, 3'b001);
    rreg("lock reset", 8'h1c, 32'h0);
  endtask : t_lock
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 0;
    t_reset;
    t_disable;
    t_div;
    t_power;
    t_lock;
    summarize;
  end
  // Watchdog
  initial
  begin
    #100000;
    n_errors++;
    summarize;
  end
endmodule : power_saving_clock_gating_test
`default_nettype wire

// ==== testbench/psc_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module psc_asserts
  import pwr_pkg::*;
#(
  parameter int NUM_PERIPH = 32
)
(
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  // Causes
  input wire logic WAIT_EXEC_IN,
  input wire pwr_pkg::wake_req_s WAKE_IN,
  input wire logic PERIPH_RD_IN,
  input wire logic [NUM_PERIPH-1:0] STOP_IN_IDLE_IN,
  // Effects
  input wire logic PERIPH_RD_DONE_OUT,
  input wire logic PB_TICK_OUT,
  input wire logic [NUM_PERIPH-1:0] PERIPH_CLK_EN_OUT,
  input wire logic CPU_CLK_EN_OUT,
  input wire logic SYS_CLK_EN_OUT,
  input wire logic SYS_UNIT_CLK_EN_OUT,
  input wire logic [2:0] POWER_STATE_OUT
);
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);
  // Decoded state and wake causes
  wire hi = WAKE_IN.irq_valid && (WAKE_IN.irq_prio > WAKE_IN.cpu_prio);
  wire wd = WAKE_IN.wdt_timeout;
  wire ins = WAKE_IN.irq_runs_in_sleep;
  wire run = POWER_STATE_OUT == 3'b001;
  wire idl = POWER_STATE_OUT == 3'b010;
  wire slp = POWER_STATE_OUT == 3'b100;
  a_sleep_wake_hi: assert property (slp && CE_IN && (wd || hi && ins) |=> run)
    else $error("sleep did not wake");
  a_sleep_low_idle: assert property (slp && CE_IN && WAKE_IN.irq_valid && ins && !hi && !wd |=> idl)
    else $error("sleep did not drop to idle");
  a_idle_cpu_stop: assert property (idl |-> !CPU_CLK_EN_OUT && SYS_CLK_EN_OUT)
    else $error("idle clock enables wrong");
  a_idle_stop_in_idle_halt: assert property (idl |-> (PERIPH_CLK_EN_OUT & STOP_IN_IDLE_IN) == '0)
    else $error("stop in idle peripheral clocked");
  a_wait_leaves_run: assert property (run && WAIT_EXEC_IN && CE_IN |=> !run)
    else $error("wait did not halt");
  a_sleep_clk_off: assert property (slp |-> !CPU_CLK_EN_OUT && !SYS_CLK_EN_OUT)
    else $error("sleep clocks running");
  a_idle_wake_hi: assert property (idl && CE_IN && (hi || wd) |=> run)
    else $error("idle did not wake");
  a_idle_hold_low: assert property (idl && CE_IN && !hi && !wd |=> idl)
    else $error("idle left without cause");
  a_unit_clk_on: assert property (!slp |-> SYS_UNIT_CLK_EN_OUT)
    else $error("system unit clock stopped");
  a_rd_done_bound: assert property (PERIPH_RD_IN && CE_IN |-> ##[1:9] PERIPH_RD_DONE_OUT)
    else $error("peripheral read late");
  a_done_after_tick: assert property (PERIPH_RD_DONE_OUT |-> $past(PB_TICK_OUT))
    else $error("read done off bus edge");
  // Main scenarios
  c_idle: cover property (run ##1 idl);
  c_sleep: cover property (run ##1 slp);
  c_sleep_idle: cover property (slp ##1 idl);
  c_done: cover property (PERIPH_RD_DONE_OUT);
endmodule : psc_asserts
bind power_saving_clock_gating psc_asserts #(.NUM_PERIPH(NUM_PERIPH)) psc_asserts_i
(
  .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .CE_IN(CE_IN), .WAIT_EXEC_IN(WAIT_EXEC_IN),
  .WAKE_IN(WAKE_IN), .PERIPH_RD_IN(PERIPH_RD_IN), .STOP_IN_IDLE_IN(STOP_IN_IDLE_IN),
  .PERIPH_RD_DONE_OUT(PERIPH_RD_DONE_OUT), .PB_TICK_OUT(PB_TICK_OUT),
  .PERIPH_CLK_EN_OUT(PERIPH_CLK_EN_OUT), .CPU_CLK_EN_OUT(CPU_CLK_EN_OUT),
  .SYS_CLK_EN_OUT(SYS_CLK_EN_OUT), .SYS_UNIT_CLK_EN_OUT(SYS_UNIT_CLK_EN_OUT),
  .POWER_STATE_OUT(POWER_STATE_OUT)
);
`default_nettype wire
